// ===== design/gpc_pkg.sv
// constants, register map and carrier types for the 16-pin gpio port
// assumes a classic wishbone slave with 32-bit data and byte addresses
// How it works
// - every pin set input or output separately
// - lower thirteen input pins may raise interrupts
// - pins 0-14 come up as inputs
// - pins 14 and 15 output programmable divided clock
// - pin 15 driven low in reset, stays output
// - pin 15 clock runs without software setup
// - pin 15 input interrupt typed by second register
// - alternate function select takes over a pin
package gpc_pkg;
    localparam int GPC_PINS = 16;
    localparam int GPC_IRQ_PINS = 13;
    localparam int GPC_CLK_A = 14;
    localparam int GPC_CLK_B = 15;
    // register byte offsets
    localparam logic [7:0] GPC_OUT_OFS = 8'h00;
    localparam logic [7:0] GPC_DIR_OFS = 8'h04;
    localparam logic [7:0] GPC_IN_OFS = 8'h08;
    localparam logic [7:0] GPC_STAT_OFS = 8'h0C;
    localparam logic [7:0] GPC_CLR_OFS = 8'h10;
    localparam logic [7:0] GPC_IEN_OFS = 8'h14;
    localparam logic [7:0] GPC_TYPE1_OFS = 8'h18;
    localparam logic [7:0] GPC_TYPE2_OFS = 8'h1C;
    localparam logic [7:0] GPC_CLK_OFS = 8'h20;
    localparam logic [7:0] GPC_ALT_OFS = 8'h24;
    // reset values: dir bit 1 = input, pin 15 output
    localparam logic [15:0] GPC_DIR_RST = 16'h7FFF;
    localparam logic [15:0] GPC_OUT_RST = 16'h0000;
    // clock control fields: per clock high count and low count, 4 bits each
    localparam logic [31:0] GPC_CLK_RST = 32'h0002_0002;
    localparam logic [1:0] GPC_CLKSEL_RST = 2'h2;
    localparam int GPC_CLKSEL_LSB = 24;
    // fastest output: high+low = 6 cycles of 5 ns = 30 ns, i.e. 33.33 MHz
    localparam int GPC_CLK_HZ = 200_000_000;
    localparam int GPC_MAX_HZ = 33_330_000;
    localparam logic [3:0] GPC_MIN_PERIOD = 4'((GPC_CLK_HZ + GPC_MAX_HZ - 1) / GPC_MAX_HZ);
    // interrupt trigger types, 2 bits per pin
    localparam logic [1:0] GPC_TRIG_HIGH = 2'h0;
    localparam logic [1:0] GPC_TRIG_LOW = 2'h1;
    localparam logic [1:0] GPC_TRIG_RISE = 2'h2;
    localparam logic [1:0] GPC_TRIG_FALL = 2'h3;
    // wishbone request carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } gpc_wb_req_t;
    // pin bundle carrier
    typedef struct packed {
        logic [15:0] o;
        logic [15:0] oe;
    } gpc_pins_t;
endpackage : gpc_pkg

// ===== design/gpc_port.sv
// 16-pin gpio port with two programmable clock outputs and interrupts
// assumes pins synchronous-sampled through two flops, one 200 MHz clock
`timescale 1ns/1ps
module gpc_port (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // wishbone slave
    input wire gpc_pkg::gpc_wb_req_t i_wb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // pins and alternate function
    input wire logic [15:0] i_pin,
    input wire logic [15:0] i_alt_o,
    input wire logic [15:0] i_alt_oe,
    output gpc_pkg::gpc_pins_t o_pins,
    output logic [15:0] o_alt_i,
    // interrupt
    output logic o_irq
);
    import gpc_pkg::*;

    logic [15:0] out_reg; // output data bits
    logic [15:0] dir_reg; // 1 = input
    logic [15:0] alt_reg; // alternate function select
    logic [15:0] ien_reg; // interrupt enables
    logic [15:0] stat_reg; // sticky interrupt status
    logic [31:0] type1_reg; // trigger types pins 0..12
    logic [31:0] type2_reg; // trigger type pin 15 in bits 1:0
    logic [31:0] clk_reg; // clock divider control
    logic [15:0] sync1_reg; // first synchroniser stage
    logic [15:0] sync2_reg; // second stage
    logic [15:0] prev_reg; // previous synced level
    logic [15:0] evt; // trigger events this cycle
    logic [15:0] clr; // software clear pulse bits
    logic [1:0] clk_out; // divided clocks
    logic [15:0] pin_o_next;
    logic [15:0] pin_oe_next;
    logic wr_stb;
    logic rd_stb;

    // trigger decode, used for both type registers
    function automatic logic trig(input logic [1:0] t, input logic cur, input logic prv);
        case (t)
            GPC_TRIG_HIGH: trig = cur;
            GPC_TRIG_LOW: trig = !cur;
            GPC_TRIG_RISE: trig = cur && !prv;
            GPC_TRIG_FALL: trig = !cur && prv;
            default: trig = 1'b0;
        endcase
    endfunction : trig

    // one bus access per request, ack one cycle later
    // a write lands on the edge where ack is seen high,
    // the same edge at which the master ends its cycle
    assign wr_stb = i_wb.cyc && i_wb.stb && i_wb.we && o_wb_ack;
    assign rd_stb = i_wb.cyc && i_wb.stb && !i_wb.we && !o_wb_ack;
    assign clr = (wr_stb && i_wb.adr == GPC_CLR_OFS) ? i_wb.dat[15:0] : 16'h0000;

    // bus ack
    // a pulse of one cycle, never two in a row
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            o_wb_ack <= 1'b0;
        else
            o_wb_ack <= i_wb.cyc && i_wb.stb && !o_wb_ack;
    end

    // read data mux; unmapped reads return zero
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            o_wb_dat <= 32'h0000_0000;
        else if (rd_stb)
        begin
            case (i_wb.adr)
                GPC_OUT_OFS: o_wb_dat <= {16'h0000, out_reg};
                GPC_DIR_OFS: o_wb_dat <= {16'h0000, dir_reg};
                GPC_IN_OFS: o_wb_dat <= {16'h0000, sync2_reg};
                GPC_STAT_OFS: o_wb_dat <= {16'h0000, stat_reg};
                GPC_IEN_OFS: o_wb_dat <= {16'h0000, ien_reg};
                GPC_TYPE1_OFS: o_wb_dat <= type1_reg;
                GPC_TYPE2_OFS: o_wb_dat <= type2_reg;
                GPC_CLK_OFS: o_wb_dat <= clk_reg;
                GPC_ALT_OFS: o_wb_dat <= {16'h0000, alt_reg};
                default: o_wb_dat <= 32'h0000_0000;
            endcase
        end
    end

    // software-written control registers, written whatever sel holds
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            out_reg <= GPC_OUT_RST;
            dir_reg <= GPC_DIR_RST;
            alt_reg <= 16'h0000;
            ien_reg <= 16'h0000;
            type1_reg <= 32'h0000_0000;
            type2_reg <= 32'h0000_0000;
            clk_reg <= GPC_CLK_RST | (32'(GPC_CLKSEL_RST) << GPC_CLKSEL_LSB);
        end
        else if (wr_stb)
        begin
            case (i_wb.adr)
                GPC_OUT_OFS: out_reg <= i_wb.dat[15:0];
                GPC_DIR_OFS: dir_reg <= i_wb.dat[15:0];
                GPC_IEN_OFS: ien_reg <= i_wb.dat[15:0];
                GPC_TYPE1_OFS: type1_reg <= i_wb.dat;
                GPC_TYPE2_OFS: type2_reg <= i_wb.dat;
                GPC_CLK_OFS: clk_reg <= i_wb.dat;
                GPC_ALT_OFS: alt_reg <= i_wb.dat[15:0];
                default: ;
            endcase
        end
    end

    // two-stage input synchroniser and edge history
    // only the second stage feeds the edge history
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
            prev_reg <= 16'h0000;
        end
        else
        begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // event detect per pin; only input pins count
    genvar g;
    generate
        for (g = 0; g < GPC_PINS; g++)
        begin : g_evt
            if (g < GPC_IRQ_PINS)
            begin : g_lo
                assign evt[g] = dir_reg[g] && !alt_reg[g] &&
                    trig(type1_reg[2*g+1 -: 2], sync2_reg[g], prev_reg[g]);
            end
            else if (g == GPC_CLK_B)
            begin : g_15
                assign evt[g] = dir_reg[g] && !alt_reg[g] &&
                    trig(type2_reg[1:0], sync2_reg[g], prev_reg[g]);
            end
            else
            begin : g_none
                // pins 13 and 14 never interrupt
                assign evt[g] = 1'b0;
            end
        end
    endgenerate

    // sticky status; a new event wins over a clear
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            stat_reg <= 16'h0000;
        else
            stat_reg <= (stat_reg & ~clr) | evt;
    end

    // interrupt level
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            o_irq <= 1'b0;
        else
            o_irq <= |(((stat_reg & ~clr) | evt) & ien_reg);
    end

    // programmable clock generators: hi/lo counts, min period 6 cycles
    generate
        for (g = 0; g < 2; g++)
        begin : g_clk
            logic [3:0] cnt_reg;
            logic lvl_reg;
            logic [3:0] hi;
            logic [3:0] lo;
            // clamp each half so period never exceeds 33.33 MHz
            assign hi = (clk_reg[16*g+3 -: 4] < (GPC_MIN_PERIOD >> 1)) ?
                (GPC_MIN_PERIOD >> 1) : clk_reg[16*g+3 -: 4];
            assign lo = (clk_reg[16*g+7 -: 4] < (GPC_MIN_PERIOD >> 1)) ?
                (GPC_MIN_PERIOD >> 1) : clk_reg[16*g+7 -: 4];
            // count up to the current half, then flip the level
            always_ff @(posedge i_core_clk)
            begin
                if (i_reset)
                begin
                    cnt_reg <= 4'h0;
                    lvl_reg <= 1'b0;
                end
                else if (cnt_reg + 4'h1 >= (lvl_reg ? hi : lo))
                begin
                    cnt_reg <= 4'h0;
                    lvl_reg <= !lvl_reg;
                end
                else
                    cnt_reg <= cnt_reg + 4'h1;
            end
            assign clk_out[g] = lvl_reg;
        end
    endgenerate

    // pin drive mux: alternate, clock, or data bit
    always_comb
    begin
        pin_o_next = out_reg;
        pin_oe_next = ~dir_reg;
        if (clk_reg[GPC_CLKSEL_LSB])
        begin
            pin_o_next[GPC_CLK_A] = clk_out[0];
            pin_oe_next[GPC_CLK_A] = 1'b1;
        end
        if (clk_reg[GPC_CLKSEL_LSB+1] && !dir_reg[GPC_CLK_B])
            pin_o_next[GPC_CLK_B] = clk_out[1];
        // an alternate function overrides data and clock
        for (int i = 0; i < GPC_PINS; i++)
        begin
            if (alt_reg[i])
            begin
                pin_o_next[i] = i_alt_o[i];
                pin_oe_next[i] = i_alt_oe[i];
            end
        end
    end

    // registered pins; pin 15 driven low while reset
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_pins.o <= 16'h0000;
            o_pins.oe <= ~GPC_DIR_RST;
        end
        else
        begin
            o_pins.o <= pin_o_next;
            o_pins.oe <= pin_oe_next;
        end
    end

    // synced pin levels to alternate-function logic
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            o_alt_i <= 16'h0000;
        else
            o_alt_i <= sync2_reg;
    end

    // checks are held off while reset is high
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    // the registered ack is a single pulse
    ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");
    // a plain input pin is never driven
    in_no_drive_a: assert property (dir_reg[3] && !alt_reg[3] |=> !o_pins.oe[3])
        else $error("input pin driven");
    // a plain output pin shows its data bit
    out_data_a: assert property (!dir_reg[2] && !alt_reg[2] |=> o_pins.o[2] == $past(out_reg[2]))
        else $error("output pin not data bit");
    // an enabled status bit not being cleared keeps irq up
    irq_level_a: assert property (|(stat_reg & ien_reg & ~clr) |=> o_irq)
        else $error("enabled status without irq");
    // a low pin event is latched
    sticky_set_a: assert property (evt[0] |=> stat_reg[0])
        else $error("event not latched");
    // a pin 15 event is latched
    p15_irq_a: assert property (evt[GPC_CLK_B] |=> stat_reg[GPC_CLK_B])
        else $error("pin 15 event lost");
    // pin 14 has no interrupt
    upper_none_a: assert property (!stat_reg[GPC_CLK_A])
        else $error("pin 14 raised event");
    // pins come out of reset as inputs, pin 15 as output
    reset_dir_a: assert property (@(posedge i_core_clk) $fell(i_reset) |-> dir_reg == GPC_DIR_RST)
        else $error("bad reset direction");
    // pin 15 as output is driven
    p15_out_a: assert property (!dir_reg[GPC_CLK_B] && !alt_reg[GPC_CLK_B] |=> o_pins.oe[GPC_CLK_B])
        else $error("pin 15 not driven");
    // the pin 15 clock keeps running; a half lasts at most 15 cycles
    clk_toggle_a: assert property (clk_reg[GPC_CLKSEL_LSB+1] && !dir_reg[GPC_CLK_B]
        |-> ##[1:16] $changed(clk_out[1]))
        else $error("clock stalled");
    // the pin 14 clock stays high for at least three cycles
    clk_min_a: assert property ($rose(clk_out[0]) |=> !$fell(clk_out[0]) [*2])
        else $error("clock faster than limit");
    // an alternate function owns its pin's enable
    alt_take_a: assert property (alt_reg[5] |=> o_pins.oe[5] == $past(i_alt_oe[5]))
        else $error("alternate not in control");
    cov_write_c: cover property (wr_stb && i_wb.adr == GPC_DIR_OFS);
    cov_irq_c: cover property ($rose(o_irq));
    cov_clk_c: cover property ($rose(clk_out[0]));
    cov_p15_c: cover property ($rose(stat_reg[GPC_CLK_B]));
    cov_alt_c: cover property (wr_stb && i_wb.adr == GPC_ALT_OFS);
endmodule : gpc_port

// ===== bench/gpc_board.sv
// board model for the gpio port: pull-ups plus optional board drivers
// assumes the port drives a pin only while its enable is high
`timescale 1ns/1ps
module gpc_board (
    // port side
    input wire gpc_pkg::gpc_pins_t i_pins,
    // board drivers set by the bench
    input wire logic [15:0] i_ext_o,
    input wire logic [15:0] i_ext_oe,
    // resolved wire levels
    output logic [15:0] o_level
);
    import gpc_pkg::*;
    // port first, then board driver, else the pull-up holds it high
    always_comb
    begin
        for (int k = 0; k < GPC_PINS; k++)
        begin
            o_level[k] = i_pins.oe[k] ? i_pins.o[k] : (i_ext_oe[k] ? i_ext_o[k] : 1'b1);
        end
    end
endmodule : gpc_board

// ===== bench/gpc_port_tb.sv
// bench for the gpio port: register rows, pin levels, interrupts, clocks
// assumes the pulled-up board model and a 200 MHz core clock
`timescale 1ns/1ps
module gpc_port_tb;
    import gpc_pkg::*;
    // one bus row: direction, offset, write data or expected read
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
    } gpc_row_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    gpc_wb_req_t wb = '0;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic [15:0] level;
    logic [15:0] ext_o = 16'h0000; // pin 9 held low by the board
    logic [15:0] ext_oe = 16'h0200;
    logic [15:0] alt_o = 16'h0001; // alternate drive on pin 0
    gpc_pins_t pins;
    logic [15:0] alt_i;
    logic irq;
    int num_errors = 0;
    int total_checks = 0;
    int hi;
    int lo;
    logic [31:0] q;
    gpc_row_t rows [14] = '{
        '{1'b0, GPC_DIR_OFS, 32'h0000_7FFF},
        '{1'b0, GPC_CLK_OFS, 32'h0202_0002},
        '{1'b1, GPC_OUT_OFS, 32'h0000_1234},
        '{1'b1, GPC_DIR_OFS, 32'h0000_FF00},
        '{1'b0, 8'h30, 32'h0000_0000},
        '{1'b1, 8'h30, 32'hFFFF_FFFF},
        '{1'b0, GPC_OUT_OFS, 32'h0000_1234},
        '{1'b0, GPC_IN_OFS, 32'h0000_FD34},
        '{1'b0, GPC_DIR_OFS, 32'h0000_FF00},
        '{1'b1, GPC_TYPE2_OFS, 32'h0000_0003},
        '{1'b1, GPC_TYPE1_OFS, 32'h03FB_FFFF},
        '{1'b1, GPC_CLR_OFS, 32'h0000_FFFF},
        '{1'b1, GPC_IEN_OFS, 32'h0000_0200},
        '{1'b0, GPC_STAT_OFS, 32'h0000_0000}
    };
    // 5 ns clock
    always #2.5 core_clk = ~core_clk;
    gpc_port i_gpc_port (
        .i_core_clk(core_clk),
        .i_reset(reset),
        .i_wb(wb),
        .o_wb_dat(wb_dat),
        .o_wb_ack(wb_ack),
        .i_pin(level),
        .i_alt_o(alt_o),
        .i_alt_oe(alt_o),
        .o_pins(pins),
        .o_alt_i(alt_i),
        .o_irq(irq)
    );
    gpc_board i_gpc_board (
        .i_pins(pins),
        .i_ext_o(ext_o),
        .i_ext_oe(ext_oe),
        .o_level(level)
    );
    // compare and count
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", what, e, g);
            num_errors++;
        end
    endtask : check
    // one classic cycle, held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        q = wb_dat;
        wb <= '0;
        if (n >= 50)
        begin
            check("bus ack", 32'h1, 32'h0);
        end
    endtask : wb_xfer
    // read and compare
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 32'h0);
        check("register read", e, q);
    endtask : rd
    // high and low run lengths of a clock pin, in core cycles
    task automatic measure(input int p);
        int n;
        n = 0;
        while (pins.o[p] !== 1'b1 && n < 99) begin @(negedge core_clk); n++; end
        while (pins.o[p] !== 1'b0 && n < 99) begin @(negedge core_clk); n++; end
        while (pins.o[p] !== 1'b1 && n < 99) begin @(negedge core_clk); n++; end
        hi = 0;
        lo = 0;
        while (pins.o[p] === 1'b1 && hi < 99) begin @(negedge core_clk); hi++; end
        while (pins.o[p] === 1'b0 && lo < 99) begin @(negedge core_clk); lo++; end
    endtask : measure
    // counts, then the verdict
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    // watchdog: the sequence needs well under 2000 cycles
    initial
    begin
        #50000;
        num_errors++;
        complete_run();
    end
    // main sequence
    initial
    begin
        repeat (2) @(negedge core_clk);
        check("reset drive", 32'h8000_0000, {pins.oe, pins.o});
        @(posedge core_clk);
        reset <= 1'b0;
        measure(15);
        check("pin15 clock", 32'h0003_0003, {hi[15:0], lo[15:0]});
        foreach (rows[k])
        begin
            wb_xfer(rows[k].we, rows[k].adr, rows[k].dat);
            if (!rows[k].we) check("row read", rows[k].dat, q);
        end
        @(negedge core_clk);
        check("pin drive", 32'h00FF_0034, {pins.oe, 8'h00, pins.o[7:0]});
        check("irq idle", 32'h0, 32'(irq));
        @(posedge core_clk);
        ext_o <= 16'h0200;
        repeat (6) @(posedge core_clk);
        rd(GPC_STAT_OFS, 32'h0000_0200);
        @(negedge core_clk);
        check("irq rise", 32'h1, 32'(irq));
        check("synced pin", 32'h1, 32'(alt_i[9]));
        wb_xfer(1'b1, GPC_IEN_OFS, 32'h0);
        repeat (2) @(negedge core_clk);
        check("irq masked", 32'h0, 32'(irq));
        @(posedge core_clk);
        ext_oe <= 16'h8200;
        wb_xfer(1'b1, GPC_IEN_OFS, 32'h8000);
        repeat (6) @(posedge core_clk);
        rd(GPC_STAT_OFS, 32'h0000_8200);
        @(negedge core_clk);
        check("irq pin15", 32'h1, 32'(irq));
        wb_xfer(1'b1, GPC_CLR_OFS, 32'h8200);
        rd(GPC_STAT_OFS, 32'h0);
        @(negedge core_clk);
        check("irq cleared", 32'h0, 32'(irq));
        wb_xfer(1'b1, GPC_ALT_OFS, 32'h1);
        repeat (2) @(negedge core_clk);
        check("alt takeover", 32'h3, {30'h0, pins.oe[0], pins.o[0]});
        wb_xfer(1'b1, GPC_DIR_OFS, 32'h0000_BF00);
        wb_xfer(1'b1, GPC_CLK_OFS, 32'h0100_0054);
        measure(14);
        check("pin14 clock", 32'h0004_0005, {hi[15:0], lo[15:0]});
        // reset again in mid-run: drive, directions and clock come back
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check("reset again", 32'h8000_0000, {pins.oe, pins.o});
        rd(GPC_DIR_OFS, 32'h0000_7FFF);
        rd(GPC_CLK_OFS, 32'h0202_0002);
        measure(15);
        check("pin15 clock again", 32'h0003_0003, {hi[15:0], lo[15:0]});
        complete_run();
    end
endmodule : gpc_port_tb
